// *** verilog/tcw_pkg.sv ***
// tcw_pkg.sv - constants and types for the terminal control word register bank
package tcw_pkg;
   // ****************************************************************
   // register addresses (word addresses on the host bus)
   // ****************************************************************
   localparam logic [3:0] TCW_ADDR_CMD = 4'h3;
   localparam logic [3:0] TCW_ADDR_CTRL = 4'h4;
   // ****************************************************************
   // start/reset command bit positions
   // ****************************************************************
   localparam int TCW_B_SOFT_RESET = 0;
   localparam int TCW_B_RUN = 1;
   localparam int TCW_B_IRQ_CLR = 2;
   localparam int TCW_B_TS_CLR = 3;
   localparam int TCW_B_TS_STEP = 4;
   localparam int TCW_B_HALT_FRAME = 5;
   localparam int TCW_B_HALT_MSG = 6;
   localparam int TCW_B_PROT_TEST = 7;
   localparam logic [2:0] TCW_TSRES_SOFT = 3'h6;
   // ****************************************************************
   // controller message control word fields
   // ****************************************************************
   localparam int TCW_C_SYNC_TS = 15;
   localparam int TCW_C_ME = 14;
   localparam int TCW_C_SRQ = 13;
   localparam int TCW_C_BUSY = 12;
   localparam int TCW_C_SSYS = 11;
   localparam int TCW_C_TF = 10;
   localparam int TCW_C_RSV = 9;
   localparam int TCW_C_RETRY = 8;
   localparam int TCW_C_BUSA = 7;
   localparam int TCW_C_LOOP = 6;
   localparam int TCW_C_BCR = 5;
   localparam int TCW_C_EOM = 4;
   localparam int TCW_C_REV = 3;
   localparam int TCW_C_FMT_LO = 0;
   // received status word bit positions (bit 0 = lsb of status word field)
   localparam int TCW_S_ME = 10;
   localparam int TCW_S_SRQ = 8;
   localparam int TCW_S_RSV_LO = 5;
   localparam int TCW_S_BCR = 4;
   localparam int TCW_S_BUSY = 3;
   localparam int TCW_S_SSYS = 2;
   localparam int TCW_S_TF = 0;
   // ****************************************************************
   // subaddress control word fields
   // ****************************************************************
   localparam int TCW_A_GLOBAL = 15;
   localparam int TCW_A_TX_EOM = 14;
   localparam int TCW_A_TX_WRAP = 13;
   localparam int TCW_A_TX_LO = 10;
   localparam int TCW_A_RX_EOM = 9;
   localparam int TCW_A_RX_WRAP = 8;
   localparam int TCW_A_RX_LO = 5;
   localparam int TCW_A_BC_EOM = 4;
   localparam int TCW_A_BC_WRAP = 3;
   localparam int TCW_A_BC_LO = 0;
   localparam logic [2:0] TCW_MEM_SINGLE = 3'h0;
   localparam logic [2:0] TCW_MEM_GRING = 3'h7;
   localparam logic [3:0] TCW_RING_BASE_LOG2 = 4'h6;
   localparam logic [15:0] TCW_WORD_RESET = 16'h0000;
   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      TCW_FMT_BC_RT,
      TCW_FMT_RT_RT,
      TCW_FMT_BCAST,
      TCW_FMT_BCAST_RT_RT,
      TCW_FMT_MODE,
      TCW_FMT_UNUSED5,
      TCW_FMT_BCAST_MODE,
      TCW_FMT_UNUSED7
   } tcw_fmt_t;
   typedef enum logic [1:0] {
      TCW_BUF_SINGLE,
      TCW_BUF_RING,
      TCW_BUF_GDOUBLE,
      TCW_BUF_GRING
   } tcw_buf_t;
endpackage

// *** verilog/tcw_buf_decode.sv ***
// tcw_buf_decode.sv - decodes one buffer-mode field of the subaddress word
`timescale 1ns/1ps
`default_nettype none
module tcw_buf_decode (
   // field and context
   input wire logic [2:0] code_i,
   input wire logic global_i,
   input wire logic is_tx_i,
   input wire logic per_sa_en_i,
   // decoded mode
   output tcw_pkg::tcw_buf_t mode_o,
   output logic [13:0] ring_words_o,
   output logic illegal_o
);
   logic glob;
   always_comb begin
      glob = global_i && !is_tx_i;
      mode_o = tcw_pkg::TCW_BUF_SINGLE;
      ring_words_o = 14'h0000;
      illegal_o = 1'b0;
      if (glob) begin
         if (code_i == tcw_pkg::TCW_MEM_SINGLE) begin
            mode_o = tcw_pkg::TCW_BUF_GDOUBLE;
         end else if (code_i == tcw_pkg::TCW_MEM_GRING) begin
            mode_o = tcw_pkg::TCW_BUF_GRING;
         end else begin
            illegal_o = 1'b1;
         end
      end else if (code_i != tcw_pkg::TCW_MEM_SINGLE) begin
         mode_o = tcw_pkg::TCW_BUF_RING;
         ring_words_o = 14'h0001 << (4'(code_i) + tcw_pkg::TCW_RING_BASE_LOG2);
         // per-subaddress choice needs enhanced buffering for rx/bcast
         illegal_o = !is_tx_i && !per_sa_en_i;
      end
   end
endmodule
`default_nettype wire

// *** verilog/tcw_regs.sv ***
// tcw_regs.sv - start/reset command pulses and control word registers
`timescale 1ns/1ps
`default_nettype none
module tcw_regs (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // host register port
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   // terminal context
   input wire logic ctrl_mode_i,
   input wire logic term_active_i,
   input wire logic [2:0] timestamp_resolution_i,
   input wire logic sync_data_cfg_i,
   input wire logic per_subaddr_buffering_en_i,
   input wire logic eom_irq_enabled_i,
   input wire logic rx_word_valid_i,
   input wire logic [15:0] rx_word_i,
   // received status word check
   input wire logic [10:0] status_word_i,
   input wire logic msg_done_i,
   // command pulses
   output logic protocol_test_start_o,
   output logic halt_at_message_end_o,
   output logic halt_at_frame_end_o,
   output logic timestamp_step_o,
   output logic timestamp_clear_o,
   output logic irq_status_clear_o,
   output logic controller_monitor_run_o,
   output logic soft_reset_cmd_o,
   // controller word decodes
   output logic sync_data_from_timestamp_o,
   output logic [10:0] status_seen_o,
   output logic status_flagged_o,
   output logic retry_allow_o,
   output logic primary_bus_select_o,
   output logic bus_tx_enable_o,
   output logic eom_irq_req_o,
   output logic protocol_revision_select_o,
   output tcw_pkg::tcw_fmt_t message_format_o,
   output logic format_unused_o,
   // subaddress word decodes
   output logic [5:0] sa_irq_en_o,
   output tcw_pkg::tcw_buf_t tx_buf_mode_o,
   output tcw_pkg::tcw_buf_t rx_buf_mode_o,
   output tcw_pkg::tcw_buf_t bcast_buf_mode_o,
   output logic [13:0] tx_ring_words_o,
   output logic [13:0] rx_ring_words_o,
   output logic [13:0] bcast_ring_words_o,
   output logic buf_cfg_illegal_o
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [15:0] ctrl_word;
      logic [15:0] sa_word;
      logic [15:0] rdata;
      logic [7:0] cmd;
      logic sync_ts;
      logic [10:0] seen;
      logic flagged;
      logic eom_irq;
      tcw_pkg::tcw_fmt_t fmt;
      logic fmt_bad;
      tcw_pkg::tcw_buf_t txm;
      tcw_pkg::tcw_buf_t rxm;
      tcw_pkg::tcw_buf_t bcm;
      logic [13:0] txw;
      logic [13:0] rxw;
      logic [13:0] bcw;
      logic bad;
      logic tx_en;
   } tcw_state_t;
   tcw_state_t st_reg;
   tcw_state_t st_next;
   tcw_pkg::tcw_buf_t dec_mode [3];
   logic [13:0] dec_words [3];
   logic [2:0] dec_bad;
   logic [10:0] mask_vec;
   // ****************************************************************
   // buffer field decoders
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_dec
         localparam int LO = (g == 0) ? tcw_pkg::TCW_A_TX_LO :
                             (g == 1) ? tcw_pkg::TCW_A_RX_LO : tcw_pkg::TCW_A_BC_LO;
         tcw_buf_decode u_dec (
            .code_i(st_reg.sa_word[LO +: 3]),
            .global_i(st_reg.sa_word[tcw_pkg::TCW_A_GLOBAL]),
            .is_tx_i(g == 0),
            .per_sa_en_i(per_subaddr_buffering_en_i),
            .mode_o(dec_mode[g]),
            .ring_words_o(dec_words[g]),
            .illegal_o(dec_bad[g])
         );
      end
   endgenerate
   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic wr_cmd;
      logic [15:0] cw;
      wr_cmd = wr_i && (addr_i == tcw_pkg::TCW_ADDR_CMD);
      cw = st_reg.ctrl_word;
      st_next = st_reg;
      // one-cycle pulses, nothing stored beyond the cycle; reserved bits ignored
      st_next.cmd = wr_cmd ? wdata_i[7:0] : 8'h00;
      // frame-end stop command only means something in controller/monitor role; message-end stop passes in any role
      if (!ctrl_mode_i) begin
         st_next.cmd[tcw_pkg::TCW_B_HALT_FRAME] = 1'b0;
      end
      // time tag step only under software-step resolution
      if (timestamp_resolution_i != tcw_pkg::TCW_TSRES_SOFT) begin
         st_next.cmd[tcw_pkg::TCW_B_TS_STEP] = 1'b0;
      end
      // shared offset: controller role maps to control word, else subaddress word
      if (wr_i && addr_i == tcw_pkg::TCW_ADDR_CTRL) begin
         if (ctrl_mode_i) begin
            st_next.ctrl_word = wdata_i;
         end else if (!term_active_i) begin
            st_next.sa_word = wdata_i;
         end
      end
      if (!ctrl_mode_i && term_active_i && rx_word_valid_i) begin
         st_next.sa_word = rx_word_i;
      end
      // kept in its own flop so the enable pin has no inverter after the register
      st_next.tx_en = !st_next.ctrl_word[tcw_pkg::TCW_C_LOOP];
      st_next.rdata = 16'h0000;
      if (rd_i && addr_i == tcw_pkg::TCW_ADDR_CTRL) begin
         st_next.rdata = ctrl_mode_i ? st_reg.ctrl_word : st_reg.sa_word;
      end
      st_next.sync_ts = cw[tcw_pkg::TCW_C_SYNC_TS] && sync_data_cfg_i;
      st_next.seen = status_word_i & ~mask_vec;
      st_next.flagged = |(status_word_i & ~mask_vec);
      st_next.eom_irq = msg_done_i && cw[tcw_pkg::TCW_C_EOM] && eom_irq_enabled_i;
      st_next.fmt = tcw_pkg::tcw_fmt_t'(cw[tcw_pkg::TCW_C_FMT_LO +: 3]);
      st_next.fmt_bad = (st_next.fmt == tcw_pkg::TCW_FMT_UNUSED5) || (st_next.fmt == tcw_pkg::TCW_FMT_UNUSED7);
      st_next.txm = dec_mode[0];
      st_next.rxm = dec_mode[1];
      st_next.bcm = dec_mode[2];
      st_next.txw = dec_words[0];
      st_next.rxw = dec_words[1];
      st_next.bcw = dec_words[2];
      st_next.bad = |dec_bad;
   end
   always_comb begin
      mask_vec = 11'h000;
      mask_vec[tcw_pkg::TCW_S_ME] = st_reg.ctrl_word[tcw_pkg::TCW_C_ME];
      mask_vec[tcw_pkg::TCW_S_SRQ] = st_reg.ctrl_word[tcw_pkg::TCW_C_SRQ];
      mask_vec[tcw_pkg::TCW_S_RSV_LO +: 3] = {3{st_reg.ctrl_word[tcw_pkg::TCW_C_RSV]}};
      mask_vec[tcw_pkg::TCW_S_BCR] = st_reg.ctrl_word[tcw_pkg::TCW_C_BCR];
      mask_vec[tcw_pkg::TCW_S_BUSY] = st_reg.ctrl_word[tcw_pkg::TCW_C_BUSY];
      mask_vec[tcw_pkg::TCW_S_SSYS] = st_reg.ctrl_word[tcw_pkg::TCW_C_SSYS];
      mask_vec[tcw_pkg::TCW_S_TF] = st_reg.ctrl_word[tcw_pkg::TCW_C_TF];
   end
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
         // loopback bit clears in reset, so the transmitter comes up enabled
         st_reg.tx_en <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end
   // ****************************************************************
   // outputs
   // ****************************************************************
   assign rdata_o = st_reg.rdata;
   assign protocol_test_start_o = st_reg.cmd[tcw_pkg::TCW_B_PROT_TEST];
   assign halt_at_message_end_o = st_reg.cmd[tcw_pkg::TCW_B_HALT_MSG];
   assign halt_at_frame_end_o = st_reg.cmd[tcw_pkg::TCW_B_HALT_FRAME];
   assign timestamp_step_o = st_reg.cmd[tcw_pkg::TCW_B_TS_STEP];
   assign timestamp_clear_o = st_reg.cmd[tcw_pkg::TCW_B_TS_CLR];
   assign irq_status_clear_o = st_reg.cmd[tcw_pkg::TCW_B_IRQ_CLR];
   assign controller_monitor_run_o = st_reg.cmd[tcw_pkg::TCW_B_RUN];
   assign soft_reset_cmd_o = st_reg.cmd[tcw_pkg::TCW_B_SOFT_RESET];
   assign sync_data_from_timestamp_o = st_reg.sync_ts;
   assign status_seen_o = st_reg.seen;
   assign status_flagged_o = st_reg.flagged;
   assign retry_allow_o = st_reg.ctrl_word[tcw_pkg::TCW_C_RETRY];
   assign primary_bus_select_o = st_reg.ctrl_word[tcw_pkg::TCW_C_BUSA];
   assign bus_tx_enable_o = st_reg.tx_en;
   assign eom_irq_req_o = st_reg.eom_irq;
   assign protocol_revision_select_o = st_reg.ctrl_word[tcw_pkg::TCW_C_REV];
   assign message_format_o = st_reg.fmt;
   assign format_unused_o = st_reg.fmt_bad;
   assign sa_irq_en_o = {st_reg.sa_word[tcw_pkg::TCW_A_TX_EOM], st_reg.sa_word[tcw_pkg::TCW_A_TX_WRAP],
                         st_reg.sa_word[tcw_pkg::TCW_A_RX_EOM], st_reg.sa_word[tcw_pkg::TCW_A_RX_WRAP],
                         st_reg.sa_word[tcw_pkg::TCW_A_BC_EOM], st_reg.sa_word[tcw_pkg::TCW_A_BC_WRAP]};
   assign tx_buf_mode_o = st_reg.txm;
   assign rx_buf_mode_o = st_reg.rxm;
   assign bcast_buf_mode_o = st_reg.bcm;
   assign tx_ring_words_o = st_reg.txw;
   assign rx_ring_words_o = st_reg.rxw;
   assign bcast_ring_words_o = st_reg.bcw;
   assign buf_cfg_illegal_o = st_reg.bad;
endmodule
`default_nettype wire

// *** test/tcw_regs_chk.sv ***
// tcw_regs_chk.sv - assertion checker bound to the control word register bank
`timescale 1ns/1ps
`default_nettype none
module tcw_regs_chk (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // host port and context
   input wire logic wr_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic ctrl_mode_i,
   input wire logic term_active_i,
   input wire logic [2:0] timestamp_resolution_i,
   input wire logic eom_irq_enabled_i,
   input wire logic rx_word_valid_i,
   input wire logic msg_done_i,
   // watched outputs
   input wire logic protocol_test_start_o,
   input wire logic halt_at_frame_end_o,
   input wire logic timestamp_step_o,
   input wire logic controller_monitor_run_o,
   input wire logic soft_reset_cmd_o,
   input wire logic primary_bus_select_o,
   input wire logic bus_tx_enable_o,
   input wire logic eom_irq_req_o,
   input wire logic [5:0] sa_irq_en_o
);
   logic w_cmd;
   logic w_word;
   assign w_cmd = wr_i && addr_i == tcw_pkg::TCW_ADDR_CMD;
   assign w_word = wr_i && addr_i == tcw_pkg::TCW_ADDR_CTRL;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);
   property p_prot; w_cmd && wdata_i[7] |=> protocol_test_start_o; endproperty
   a_prot: assert property (p_prot) else $error("self-test pulse missing");
   property p_frame; w_cmd && wdata_i[5] |=> halt_at_frame_end_o == $past(ctrl_mode_i); endproperty
   a_frame: assert property (p_frame) else $error("frame halt pulse wrong");
   property p_step; w_cmd && wdata_i[4] |=> timestamp_step_o == $past(timestamp_resolution_i == 3'h6); endproperty
   a_step: assert property (p_step) else $error("time step pulse wrong");
   property p_run; w_cmd && wdata_i[1] |=> controller_monitor_run_o; endproperty
   a_run: assert property (p_run) else $error("run pulse missing");
   property p_soft; !(w_cmd && wdata_i[0]) |=> !soft_reset_cmd_o; endproperty
   a_soft: assert property (p_soft) else $error("soft reset pulse without write");
   property p_bus; w_word && ctrl_mode_i |=> primary_bus_select_o == $past(wdata_i[7]) && bus_tx_enable_o != $past(wdata_i[6]);
   endproperty
   a_bus: assert property (p_bus) else $error("bus select or loopback wrong");
   property p_eom; eom_irq_req_o |-> $past(msg_done_i && eom_irq_enabled_i); endproperty
   a_eom: assert property (p_eom) else $error("end of message request without cause");
   property p_sa; w_word && !ctrl_mode_i && term_active_i && !rx_word_valid_i |=> $stable(sa_irq_en_o); endproperty
   a_sa: assert property (p_sa) else $error("subaddress word written while active");
endmodule
bind tcw_regs tcw_regs_chk u_chk (.*);
`default_nettype wire

// *** test/tcw_host_model.sv ***
// tcw_host_model.sv - host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module tcw_host_model (
   // clock and read data
   input wire logic mclk_i,
   input wire logic [15:0] rdata_i,
   // host strobes
   output logic wr_o,
   output logic rd_o,
   output logic [3:0] addr_o,
   output logic [15:0] wdata_o
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 4'h0;
      wdata_o = 16'h0000;
   end
   // one access: request held over the taking edge, then the bus is scrambled
   task automatic put(input logic [3:0] a, input logic [15:0] d, input logic rd, output logic [15:0] q);
      @(posedge mclk_i);
      #1;
      addr_o = a;
      wr_o = !rd;
      rd_o = rd;
      wdata_o = (a == tcw_pkg::TCW_ADDR_CMD) ? (d & 16'h0eff) : d;
      @(posedge mclk_i);
      #1;
      q = rdata_i;
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = ~addr_o;
      wdata_o = ~wdata_o;
   endtask
endmodule
`default_nettype wire

// *** test/tcw_regs_test.sv ***
// tcw_regs_test.sv - self-checking testbench for the control word register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tcw_regs_test;
   logic mclk_i, rstn_i, wr_i, rd_i, ctrl_mode_i, term_active_i, sync_data_cfg_i, per_subaddr_buffering_en_i;
   logic eom_irq_enabled_i, rx_word_valid_i, msg_done_i, protocol_test_start_o, halt_at_message_end_o;
   logic halt_at_frame_end_o, timestamp_step_o, timestamp_clear_o, irq_status_clear_o, controller_monitor_run_o;
   logic soft_reset_cmd_o, sync_data_from_timestamp_o, status_flagged_o, retry_allow_o, primary_bus_select_o;
   logic bus_tx_enable_o, eom_irq_req_o, protocol_revision_select_o, format_unused_o, buf_cfg_illegal_o, ill;
   logic [3:0] addr_i;
   logic [15:0] wdata_i, rdata_o, rx_word_i, d, q;
   logic [2:0] timestamp_resolution_i;
   logic [10:0] status_word_i, status_seen_o;
   logic [5:0] sa_irq_en_o;
   logic [13:0] tx_ring_words_o, rx_ring_words_o, bcast_ring_words_o;
   logic [7:0] pv;
   tcw_pkg::tcw_fmt_t message_format_o;
   tcw_pkg::tcw_buf_t tx_buf_mode_o, rx_buf_mode_o, bcast_buf_mode_o;
   integer seed, i, compares, mismatches, cycles;
   tcw_regs uut (.*);
   tcw_host_model host (.mclk_i(mclk_i), .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
   assign pv = {protocol_test_start_o, halt_at_message_end_o, halt_at_frame_end_o, timestamp_step_o,
      timestamp_clear_o, irq_status_clear_o, controller_monitor_run_o, soft_reset_cmd_o};
   function automatic logic [7:0] cmd_exp(input logic [7:0] c, input logic [2:0] r, input logic m);
      cmd_exp = c;
      cmd_exp[5] = c[5] & m;
      cmd_exp[4] = c[4] & (r == tcw_pkg::TCW_TSRES_SOFT);
   endfunction
   function automatic logic [10:0] mask_exp(input logic [15:0] w);
      return {w[14], 1'b0, w[13], {3{w[9]}}, w[5], w[12], w[11], 1'b0, w[10]};
   endfunction
   function automatic tcw_pkg::tcw_buf_t buf_exp(input logic [2:0] c, input logic g, input logic tx);
      if (tx || !g) return (c == 3'h0) ? tcw_pkg::TCW_BUF_SINGLE : tcw_pkg::TCW_BUF_RING;
      return (c == 3'h7) ? tcw_pkg::TCW_BUF_GRING : tcw_pkg::TCW_BUF_GDOUBLE;
   endfunction
   task tally_and_finish;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // hang guard, far above the roughly 540 cycles the run needs
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish;
      end
   end
   initial begin
      {seed, compares, mismatches, cycles} = {32'h3c28e0d1, 96'h0};
      {rstn_i, ctrl_mode_i, term_active_i, sync_data_cfg_i, eom_irq_enabled_i} = 5'h08;
      {rx_word_valid_i, msg_done_i, rx_word_i, status_word_i, timestamp_resolution_i} = '0;
      per_subaddr_buffering_en_i = 1'b1;
      repeat (10) @(posedge mclk_i);
      #1 rstn_i = 1'b1;
      `CHK({pv, bus_tx_enable_o}, 9'h001)
      for (i = 0; i < 40; i++) begin
         d = (i < 8) ? 16'h0001 << i : 16'($random(seed));
         ctrl_mode_i = (i < 8) | 1'($random(seed));
         timestamp_resolution_i = (i < 8 || i[0]) ? tcw_pkg::TCW_TSRES_SOFT : 3'($random(seed));
         host.put(tcw_pkg::TCW_ADDR_CMD, d, 1'b0, q);
         `CHK(pv, cmd_exp(d[7:0], timestamp_resolution_i, ctrl_mode_i))
         @(posedge mclk_i);
         #1;
         `CHK(pv, 8'h00)
      end
      $display("test start/reset commands done");
      ctrl_mode_i = 1'b1;
      for (i = 0; i < 24; i++) begin
         d = (i == 1) ? 16'hffff : {16'($random(seed)) & 16'hfff8 | 16'(i[2:0])};
         {sync_data_cfg_i, eom_irq_enabled_i, status_word_i} = 13'($random(seed));
         host.put(tcw_pkg::TCW_ADDR_CTRL, d, 1'b0, q);
         `CHK({retry_allow_o, primary_bus_select_o, bus_tx_enable_o, protocol_revision_select_o}, {d[8:7], !d[6], d[3]})
         msg_done_i = 1'b1;
         @(posedge mclk_i);
         #1 msg_done_i = 1'b0;
         `CHK({sync_data_from_timestamp_o, eom_irq_req_o}, {d[15] & sync_data_cfg_i, d[4] & eom_irq_enabled_i})
         `CHK({status_flagged_o, status_seen_o}, {|(status_word_i & ~mask_exp(d)), status_word_i & ~mask_exp(d)})
         `CHK({message_format_o, format_unused_o}, {d[2:0], d[2] & d[0]})
         host.put(tcw_pkg::TCW_ADDR_CTRL, 16'h0000, 1'b1, q);
         `CHK(q, d)
      end
      host.put(4'h5, 16'h0000, 1'b1, q);
      `CHK(q, 16'h0000)
      $display("test controller word done");
      ctrl_mode_i = 1'b0;
      for (i = 0; i < 24; i++) begin
         d = 16'($random(seed));
         if (i[1]) d[7:0] = {{3{i[2]}}, d[4:3], {3{i[3]}}};
         per_subaddr_buffering_en_i = !i[0];
         ill = d[15] ? (!(d[7:5] inside {3'h0, 3'h7}) | !(d[2:0] inside {3'h0, 3'h7})) :
            (i[0] & (d[7:5] != 3'h0 || d[2:0] != 3'h0));
         term_active_i = 1'b0;
         host.put(tcw_pkg::TCW_ADDR_CTRL, d, 1'b0, q);
         `CHK(sa_irq_en_o, {d[14:13], d[9:8], d[4:3]})
         @(posedge mclk_i);
         #1;
         `CHK(tx_buf_mode_o, buf_exp(d[12:10], d[15], 1'b1))
         if (d[12:10] != 3'h0) `CHK(tx_ring_words_o, 14'h0040 << d[12:10])
         if (!d[15] && d[7:5] != 3'h0) `CHK(rx_ring_words_o, 14'h0040 << d[7:5])
         `CHK(bcast_ring_words_o, (d[15] || d[2:0] == 3'h0) ? 14'h0000 : 14'h0040 << d[2:0])
         `CHK(buf_cfg_illegal_o, ill)
         if (!ill) `CHK({rx_buf_mode_o, bcast_buf_mode_o}, {buf_exp(d[7:5], d[15], 1'b0), buf_exp(d[2:0], d[15], 1'b0)})
         host.put(tcw_pkg::TCW_ADDR_CTRL, 16'h0000, 1'b1, q);
         `CHK(q, d)
         term_active_i = 1'b1;
         host.put(tcw_pkg::TCW_ADDR_CTRL, ~d, 1'b0, q);
         host.put(tcw_pkg::TCW_ADDR_CTRL, 16'h0000, 1'b1, q);
         `CHK(q, d)
         rx_word_i = 16'($random(seed));
         rx_word_valid_i = 1'b1;
         @(posedge mclk_i);
         #1 rx_word_valid_i = 1'b0;
         host.put(tcw_pkg::TCW_ADDR_CTRL, 16'h0000, 1'b1, q);
         `CHK(q, rx_word_i)
      end
      $display("test subaddress word done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
